/* File: include/vsq_pkg.sv */
// Package for the regulator startup, shutdown and fault sequencer
package vsq_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned PHASES = 4;           // Phase pulse outputs
    localparam int unsigned TGT_W = 8;            // Target code width
    localparam int unsigned ILIM_W = 4;           // Peak limit level width

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_NS = 100;         // Clock period in ns
    localparam int unsigned PGOOD_DLY_US = 20;    // Power-good blanking
    localparam int unsigned PGOOD_DLY_CYC = (PGOOD_DLY_US * 1000) / CLK_NS;
    localparam int unsigned RAMP_DIV = 4;         // Ramp at quarter slew rate

    // ****************************************************************
    // Reset values and levels
    // ****************************************************************
    localparam logic [TGT_W-1:0] TGT_ZERO = 8'h00;       // Zero-volt target
    localparam logic [ILIM_W-1:0] ILIM_FULL = 4'hF;      // Full peak limit
    localparam logic [ILIM_W-1:0] ILIM_MIN = 4'h1;       // Lowest peak limit

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        VSQ_OFF,
        VSQ_REF_UP,
        VSQ_SOFT_START,
        VSQ_RUN,
        VSQ_SOFT_STOP
    } vsq_state_e;

    // Synchronised comparator results
    typedef struct packed {
        logic supply_por;       // Supply above about 2V
        logic supply_ok;        // Supply above 4.25V lockout level
        logic supply_low;       // Supply below 1V
        logic run_request_n;    // Run request pin high
        logic test_mode;        // 11V to 13V seen on run request pin
        logic ref_ok;           // Reference in regulation
        logic battery_ok;       // Input battery present
        logic over_guard;       // Output 200mV above tracked target
        logic over_fixed;       // Output above fixed 1.75V guard
        logic below_target;     // Output below target
        logic under_guard;      // Output under 70% of nominal
        logic hot;              // Junction above 160C
        logic cooled;           // Junction cooled by 15C
        logic skip_select;      // Light-load skip select
        logic suspend_select;   // Suspend select
        logic avg_over;         // Average current limit exceeded
    } vsq_sense_s;
endpackage

/* File: logic/vsq_sync.sv */
// Two-stage synchroniser for a bundle of comparator results
`timescale 1ns/100ps
module vsq_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    // ****************************************************************
    // Synchroniser stages
    // ****************************************************************
    logic [W-1:0] meta_q;   // First stage, read only by the second
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;   // Second stage
    logic [W-1:0] sync_d;

    // Next values, held while the clock enable is low
    always_comb begin
        meta_d = clk_en_i ? async_i : meta_q;
        sync_d = clk_en_i ? meta_q : sync_q;
    end

    // Registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

/* File: logic/vsq_seq.sv */
// Startup, shutdown and fault sequencer for a multiphase regulator
// Operation
// - Peak current trip ends active on-time
// - Average over-limit lowers peak limit
// - Power-on clear resets fault latch
// - Lockout holds skip line high, pulses low
// - Reference on when supply ok, run high
// - Soft-start to code or suspend, quarter rate
// - No current-limit reduction during soft-start
// - Power-good released 20us after target reached
// - Missing battery at startup sets fault
// - Fault holds shutdown until toggle or supply
// - Supply drop forces immediate lockout shutdown
// - Run low drops power-good, ramps down
// - Soft-stop to zero target: skip line low, reference off
// - Undervoltage or thermal shutdown sets fault
// - Flag overvoltage 200mV above target
// - Skip rise fixes guard until below target
// - Overvoltage forces skip line high, no latch
// - No on-time while overvoltage present
// - Output under 70% shuts down, latches
// - Thermal trip latches; clear needs cooling
// - Test mode disables all three protections
// - Entering test mode clears fault latch
// - Ramps run in forced-PWM mode
`timescale 1ns/100ps
module vsq_seq (
    // Clock, reset and enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Analog comparator results, asynchronous
    input wire vsq_pkg::vsq_sense_s sense_i,
    // Per-phase oscillator start and peak current trip
    input wire logic [vsq_pkg::PHASES-1:0] phase_clock_i,
    input wire logic [vsq_pkg::PHASES-1:0] phase_sense_trip_i,
    // Programmed targets
    input wire logic [vsq_pkg::TGT_W-1:0] voltage_code_i,
    input wire logic [vsq_pkg::TGT_W-1:0] suspend_level_i,
    input wire logic slew_tick_i,
    // Driver side
    output logic [vsq_pkg::PHASES-1:0] phase_pulse_o,
    output logic driver_skip_line_o,
    // Power-good open drain, enable high pulls low
    output logic power_good_out_o,
    output logic power_good_out_oe_o,
    // Status
    output logic reference_on_o,
    output logic fault_latch_o,
    output logic overvoltage_guard_o,
    output logic [vsq_pkg::TGT_W-1:0] target_o,
    output logic [vsq_pkg::ILIM_W-1:0] peak_limit_o
);
    import vsq_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    vsq_sense_s sn;                       // Synchronised comparators
    logic [PHASES-1:0] trip_s;            // Synchronised peak trips
    logic [PHASES-1:0] pclk_s;            // Synchronised phase clocks

    // Every comparator passes two flops before use
    vsq_sync #(.W($bits(vsq_sense_s))) u_sync_sense (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .async_i(sense_i),
        .sync_o(sn)
    );

    vsq_sync #(.W(2 * PHASES)) u_sync_phase (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .async_i({phase_clock_i, phase_sense_trip_i}),
        .sync_o({pclk_s, trip_s})
    );

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    vsq_state_e state_q, state_d;           // Main sequence state
    logic fault_q, fault_d;                 // Single shared fault latch
    logic [TGT_W-1:0] tgt_q, tgt_d;         // Ramped output target
    logic [1:0] div_q, div_d;               // Quarter-rate tick divider
    logic [15:0] pg_cnt_q, pg_cnt_d;        // Power-good blanking count
    logic pg_q, pg_d;                       // Power-good released
    logic ref_q, ref_d;                     // Reference enable
    logic run_q, run_d;                     // Previous run request
    logic test_q, test_d;                   // Previous test mode
    logic skip_q, skip_d;                   // Previous skip select
    logic fix_q, fix_d;                     // Fixed guard in force
    logic ovp_q, ovp_d;                     // Overvoltage flag
    logic [ILIM_W-1:0] ilim_q, ilim_d;      // Peak limit level
    logic [PHASES-1:0] pulse_q, pulse_d;    // Phase pulses
    logic dskip_q, dskip_d;                 // Driver skip line

    // Derived terms
    logic [TGT_W-1:0] final_tgt;            // Target at end of soft-start
    logic qtick;                            // Quarter-rate ramp step
    logic ramping;                          // Soft-start or soft-stop
    logic prot_fault;                       // Latched protection event
    logic clear_req;                        // Latch clear event
    logic ov_now;                           // Overvoltage in force

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        fault_d = fault_q;
        tgt_d = tgt_q;
        div_d = div_q;
        pg_cnt_d = pg_cnt_q;
        pg_d = pg_q;
        ref_d = ref_q;
        ilim_d = ilim_q;
        pulse_d = pulse_q;
        dskip_d = dskip_q;

        // Record edges of the run, test and skip inputs
        run_d = sn.run_request_n;
        test_d = sn.test_mode;
        skip_d = sn.skip_select;

        final_tgt = sn.suspend_select ? suspend_level_i : voltage_code_i;
        ramping = (state_q == VSQ_SOFT_START) || (state_q == VSQ_SOFT_STOP);

        // Quarter of the programmed slew: one step every four ticks
        qtick = 1'b0;
        if (slew_tick_i) begin
            div_d = div_q + 2'd1;
            qtick = (div_q == 2'(RAMP_DIV - 1));
        end

        // Fixed guard after skip rise, released once below target
        fix_d = fix_q;
        if (sn.skip_select && !skip_q) begin
            fix_d = 1'b1;
        end else if (sn.below_target) begin
            fix_d = 1'b0;
        end
        // Overvoltage flag, tracked or fixed, idle in test mode
        ov_now = !sn.test_mode && (fix_q ? sn.over_fixed : sn.over_guard);
        ovp_d = ov_now;

        // Undervoltage and thermal only while regulating
        prot_fault = !sn.test_mode && (state_q == VSQ_RUN) &&
                     (sn.under_guard || sn.hot);

        // Clear by run toggle or supply below 1V; hot die refuses
        clear_req = ((sn.run_request_n && !run_q) || sn.supply_low) &&
                    !(sn.hot || !sn.cooled);

        // Average over-limit steps peak limit down, not in soft-start
        if (state_q == VSQ_SOFT_START || state_q == VSQ_OFF) begin
            ilim_d = ILIM_FULL;
        end else if (sn.avg_over) begin
            if (ilim_q > ILIM_MIN) begin
                ilim_d = ilim_q - 4'h1;
            end
        end else if (ilim_q != ILIM_FULL) begin
            ilim_d = ilim_q + 4'h1;
        end

        // Main sequence
        case (state_q)
            VSQ_OFF: begin
                tgt_d = TGT_ZERO;
                pg_d = 1'b0;
                pg_cnt_d = '0;
                // Start only with supply, run and clear latch
                if (sn.supply_ok && sn.run_request_n && !fault_q) begin
                    ref_d = 1'b1;
                    state_d = VSQ_REF_UP;
                end
            end
            VSQ_REF_UP: begin
                if (!sn.run_request_n) begin
                    ref_d = 1'b0;
                    state_d = VSQ_OFF;
                end else if (sn.ref_ok) begin
                    state_d = VSQ_SOFT_START;
                end
            end
            VSQ_SOFT_START: begin
                if (!sn.battery_ok) begin
                    fault_d = 1'b1;
                    state_d = VSQ_SOFT_STOP;
                end else if (!sn.run_request_n || prot_fault) begin
                    state_d = VSQ_SOFT_STOP;
                end else if (qtick && tgt_q < final_tgt) begin
                    tgt_d = tgt_q + 8'h01;
                end else if (qtick && tgt_q > final_tgt) begin
                    tgt_d = tgt_q - 8'h01;
                end else if (tgt_q == final_tgt) begin
                    state_d = VSQ_RUN;
                end
            end
            VSQ_RUN: begin
                // Track later code changes at full rate
                if (slew_tick_i && tgt_q != final_tgt) begin
                    tgt_d = (tgt_q < final_tgt) ? tgt_q + 8'h01 : tgt_q - 8'h01;
                end
                // Blanking count before releasing power-good
                if (pg_cnt_q < 16'(PGOOD_DLY_CYC)) begin
                    pg_cnt_d = pg_cnt_q + 16'h0001;
                end else begin
                    pg_d = 1'b1;
                end
                if (prot_fault) begin
                    fault_d = 1'b1;
                    pg_d = 1'b0;
                    state_d = VSQ_SOFT_STOP;
                end else if (!sn.run_request_n) begin
                    pg_d = 1'b0;
                    state_d = VSQ_SOFT_STOP;
                end
            end
            VSQ_SOFT_STOP: begin
                pg_d = 1'b0;
                pg_cnt_d = '0;
                if (tgt_q == TGT_ZERO) begin
                    ref_d = 1'b0;
                    state_d = VSQ_OFF;
                end else if (qtick) begin
                    tgt_d = tgt_q - 8'h01;
                end
            end
            default: begin
                state_d = VSQ_OFF;
            end
        endcase

        // Supply under lockout overrides everything at once
        if (!sn.supply_ok) begin
            state_d = VSQ_OFF;
            ref_d = 1'b0;
            pg_d = 1'b0;
            tgt_d = TGT_ZERO;
        end

        // Latch clearing; a new fault in the same cycle wins
        if ((clear_req || (sn.test_mode && !test_q)) &&
            !(prot_fault || (state_q == VSQ_SOFT_START && !sn.battery_ok))) begin
            fault_d = 1'b0;
        end
        // Power-on clear
        if (!sn.supply_por) begin
            fault_d = 1'b0;
        end

        // Driver skip line: high in lockout, ramps and overvoltage
        if (!sn.supply_ok) begin
            dskip_d = 1'b1;
        end else if (ov_now) begin
            dskip_d = 1'b1;
        end else if (state_d == VSQ_OFF) begin
            dskip_d = 1'b0;
        end else if (state_d == VSQ_SOFT_START || state_d == VSQ_SOFT_STOP) begin
            dskip_d = 1'b1;
        end else begin
            dskip_d = !sn.skip_select;
        end

        // Phase pulses: start on phase clock, end on peak trip
        for (int i = 0; i < PHASES; i++) begin
            if (state_d == VSQ_OFF || state_q == VSQ_OFF || state_q == VSQ_REF_UP ||
                ov_now) begin
                pulse_d[i] = 1'b0;
            end else if (trip_s[i]) begin
                pulse_d[i] = 1'b0;
            end else if (pclk_s[i] && !(sn.skip_select && !ramping && i != 0)) begin
                pulse_d[i] = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= VSQ_OFF;
            fault_q <= 1'b0;
            tgt_q <= TGT_ZERO;
            div_q <= 2'd0;
            pg_cnt_q <= 16'h0000;
            pg_q <= 1'b0;
            ref_q <= 1'b0;
            run_q <= 1'b0;
            test_q <= 1'b0;
            skip_q <= 1'b0;
            fix_q <= 1'b0;
            ovp_q <= 1'b0;
            ilim_q <= ILIM_FULL;
            pulse_q <= '0;
            dskip_q <= 1'b1;
        end else if (clk_en_i) begin
            state_q <= state_d;
            fault_q <= fault_d;
            tgt_q <= tgt_d;
            div_q <= div_d;
            pg_cnt_q <= pg_cnt_d;
            pg_q <= pg_d;
            ref_q <= ref_d;
            run_q <= run_d;
            test_q <= test_d;
            skip_q <= skip_d;
            fix_q <= fix_d;
            ovp_q <= ovp_d;
            ilim_q <= ilim_d;
            pulse_q <= pulse_d;
            dskip_q <= dskip_d;
        end
    end

    // ****************************************************************
    // Outputs, all from flops except power_good_out_o tied low
    // ****************************************************************
    assign phase_pulse_o = pulse_q;
    assign driver_skip_line_o = dskip_q;
    assign power_good_out_o = 1'b0;
    assign power_good_out_oe_o = !pg_q;
    assign reference_on_o = ref_q;
    assign fault_latch_o = fault_q;
    assign overvoltage_guard_o = ovp_q;
    assign target_o = tgt_q;
    assign peak_limit_o = ilim_q;
endmodule

/* File: dv/vsq_seq_props.sv */
// Port checker for the regulator sequencer
`timescale 1ns/100ps
module vsq_seq_props (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Inputs watched
    input wire vsq_pkg::vsq_sense_s sense_i,
    input wire logic [vsq_pkg::PHASES-1:0] phase_sense_trip_i,
    input wire logic slew_tick_i,
    // Outputs watched
    input wire logic [vsq_pkg::PHASES-1:0] phase_pulse_o,
    input wire logic driver_skip_line_o,
    input wire logic power_good_out_oe_o,
    input wire logic reference_on_o,
    input wire logic fault_latch_o,
    input wire logic overvoltage_guard_o,
    input wire logic [vsq_pkg::TGT_W-1:0] target_o
);
    import vsq_pkg::*;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    // ****************
    // Target hold count
    // ****************
    logic [TGT_W-1:0] last_q, last_d;  // Target one cycle ago
    logic [8:0] hold_q, hold_d;        // Cycles since target moved
    // Saturates so a long run never wraps back into the window
    always_comb begin
        last_d = target_o;
        hold_d = (hold_q == 9'h1FF) ? hold_q : hold_q + 9'h001;
        if (target_o != last_q) begin
            hold_d = 9'h000;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_q <= TGT_ZERO;
            hold_q <= 9'h000;
        end else begin
            last_q <= last_d;
            hold_q <= hold_d;
        end
    end
    // ****************
    // Properties
    // ****************
    // Enough samples to pass the two-stage input synchroniser
    sequence s_no_supply;
        (clk_en_i && !sense_i.supply_ok) [*4];
    endsequence
    sequence s_run_low;
        (clk_en_i && !sense_i.run_request_n) [*4];
    endsequence
    sequence s_trip;
        (clk_en_i && phase_sense_trip_i[0]) [*3];
    endsequence
    lockout_hold_a:
        assert property (s_no_supply |=> driver_skip_line_o && !(|phase_pulse_o))
        else $error("drivers active without supply");
    pgood_drop_a:
        assert property (s_run_low |=> power_good_out_oe_o)
        else $error("power good kept with run low");
    trip_stop_a:
        assert property (s_trip |=> !phase_pulse_o[0])
        else $error("on-time kept past current trip");
    ov_force_a:
        assert property (overvoltage_guard_o [*2] |->
            driver_skip_line_o && !(|phase_pulse_o) && $stable(fault_latch_o))
        else $error("overvoltage response wrong");
    slew_step_a:
        assert property (reference_on_o && $past(reference_on_o) && $changed(target_o)
            |-> $past(slew_tick_i))
        else $error("target moved without slew tick");
    pgood_time_a:
        assert property ($fell(power_good_out_oe_o) |-> hold_q >= 9'h0C3 && hold_q <= 9'h0CE)
        else $error("power good release time wrong");
    fault_hold_a:
        assert property (fault_latch_o && !reference_on_o |=> !reference_on_o)
        else $error("restart while fault latched");
    off_quiet_a:
        assert property ($fell(reference_on_o) && $past(target_o) == TGT_ZERO
            |-> !driver_skip_line_o && !(|phase_pulse_o))
        else $error("drivers not parked at zero target");
endmodule

bind vsq_seq vsq_seq_props i_props (
    .clk_sys_i, .rst_b_i, .clk_en_i, .sense_i, .phase_sense_trip_i, .slew_tick_i,
    .phase_pulse_o, .driver_skip_line_o, .power_good_out_oe_o, .reference_on_o,
    .fault_latch_o, .overvoltage_guard_o, .target_o
);

/* File: dv/vsq_drv_model.sv */
// Behavioural model of the per-phase skip-mode gate drivers
`timescale 1ns/100ps
module vsq_drv_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // From the sequencer
    input wire logic [vsq_pkg::PHASES-1:0] phase_pulse_i,
    input wire logic driver_skip_line_i,
    // Current trip back, gates out
    output logic [vsq_pkg::PHASES-1:0] phase_sense_trip_o,
    output logic [vsq_pkg::PHASES-1:0] high_gate_o,
    output logic [vsq_pkg::PHASES-1:0] low_gate_o
);
    import vsq_pkg::*;
    logic [1:0] cur_q [PHASES];  // Coarse inductor current per phase
    // Current climbs in on-time and decays after it
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        for (int i = 0; i < PHASES; i++) begin
            if (!rst_b_i) begin
                cur_q[i] <= 2'h0;
            end else if (phase_pulse_i[i] && cur_q[i] != 2'h3) begin
                cur_q[i] <= cur_q[i] + 2'h1;
            end else if (!phase_pulse_i[i] && cur_q[i] != 2'h0) begin
                cur_q[i] <= cur_q[i] - 2'h1;
            end
        end
    end
    // Skip line low lets zero-cross end the low-side on-time
    always_comb begin
        for (int i = 0; i < PHASES; i++) begin
            phase_sense_trip_o[i] = (cur_q[i] == 2'h3);
            high_gate_o[i] = phase_pulse_i[i];
            low_gate_o[i] = !phase_pulse_i[i] && (driver_skip_line_i || cur_q[i] != 2'h0);
        end
    end
endmodule

/* File: dv/vsq_seq_test.sv */
// Self-checking bench of the regulator sequencer
`timescale 1ns/100ps
module vsq_seq_test;
    import vsq_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    vsq_sense_s sns;
    logic [PHASES-1:0] ph_clk = '0;
    logic [3:0] ph_cnt = 4'h0;
    logic tick = 1'b0;
    logic [TGT_W-1:0] code = 8'h10;
    logic [TGT_W-1:0] susp = 8'h06;
    logic [PHASES-1:0] trip, pulse, hg, lg;
    logic skip, pg_oe, ref_on, fault, overvoltage_guard;
    logic [TGT_W-1:0] tgt;
    logic [ILIM_W-1:0] lim;
    int err_count = 0;
    int tests_run = 0;
    vsq_seq i_dut (
        .clk_sys_i, .rst_b_i, .clk_en_i(1'b1), .sense_i(sns), .phase_clock_i(ph_clk),
        .phase_sense_trip_i(trip), .voltage_code_i(code), .suspend_level_i(susp),
        .slew_tick_i(tick), .phase_pulse_o(pulse), .driver_skip_line_o(skip),
        .power_good_out_o(), .power_good_out_oe_o(pg_oe), .reference_on_o(ref_on),
        .fault_latch_o(fault), .overvoltage_guard_o(overvoltage_guard), .target_o(tgt), .peak_limit_o(lim)
    );
    vsq_drv_model i_drv (
        .clk_sys_i, .rst_b_i, .phase_pulse_i(pulse), .driver_skip_line_i(skip),
        .phase_sense_trip_o(trip), .high_gate_o(hg), .low_gate_o(lg)
    );
    initial forever #50 clk_sys_i = ~clk_sys_i;
    // Slew tick every other cycle, on-time requests every 16
    always @(posedge clk_sys_i) begin
        #5;
        tick = ~tick;
        ph_clk = {PHASES{ph_cnt < 4'h2}};
        ph_cnt = ph_cnt + 4'h1;
    end
    // ****************
    // Helpers
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #5;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Quarter rate: 4 ticks of 2 cycles per step, then 200 cycles blanking
    task automatic power_up(input logic [7:0] exp, input int base);
        int n = base;
        sns.run_request_n = 1'b1;
        while (pg_oe !== 1'b0 && n < 3000) begin
            step(1);
            n++;
        end
        chk("target", exp, tgt);
        chk("ramp time", 8'h01, n >= 7 * exp + 195 && n <= 8 * exp + 230);
    endtask
    task automatic wait_off(output int n);
        n = 0;
        while (ref_on !== 1'b0 && n < 2000) begin
            step(1);
            n++;
        end
        chk("ref off", 8'h00, ref_on);
    endtask
    // Fault clears on the rising run edge
    task automatic toggle_run();
        sns.run_request_n = 1'b0;
        step(6);
        sns.run_request_n = 1'b1;
        step(6);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_start();
        sns.supply_ok = 1'b1;
        sns.avg_over = 1'b1;
        sns.run_request_n = 1'b1;
        step(60);
        chk("ramp limit", ILIM_FULL, lim);
        chk("reference", 1'b1, ref_on);
        power_up(code, 60);
        chk("avg limit", ILIM_MIN, lim);
        sns.avg_over = 1'b0;
        step(20);
        chk("limit back", ILIM_FULL, lim);
    endtask
    task automatic t_overvolt();
        sns.over_guard = 1'b1;
        step(4);
        chk("ov flag", 1'b1, overvoltage_guard);
        chk("ov skip", 1'b1, skip);
        chk("ov pulses", 8'h00, pulse);
        chk("ov latch", 1'b0, fault);
        sns.skip_select = 1'b1;
        step(4);
        chk("fixed guard", 1'b0, overvoltage_guard);
        sns.over_guard = 1'b0;
        sns.below_target = 1'b1;
        step(4);
        sns.below_target = 1'b0;
        sns.over_guard = 1'b1;
        step(4);
        chk("tracked guard", 1'b1, overvoltage_guard);
        sns.over_guard = 1'b0;
        step(4);
        chk("ov clear", 1'b0, overvoltage_guard);
        chk("skip mode", 1'b0, skip);
        sns.skip_select = 1'b0;
    endtask
    task automatic t_shutdown();
        int n;
        sns.run_request_n = 1'b0;
        step(4);
        chk("pg drop", 1'b1, pg_oe);
        wait_off(n);
        chk("ramp down", 8'h01, n > 100);
        chk("off skip", 1'b0, skip);
        chk("off pulses", 8'h00, pulse);
    endtask
    task automatic t_undervolt();
        int n;
        sns.suspend_select = 1'b1;
        sns.skip_select = 1'b1;
        sns.run_request_n = 1'b1;
        step(20);
        chk("ramp pwm", 1'b1, skip);
        power_up(susp, 20);
        sns.under_guard = 1'b1;
        step(4);
        chk("uv latch", 1'b1, fault);
        wait_off(n);
        sns.under_guard = 1'b0;
        step(20);
        chk("restart refused", 1'b0, ref_on);
        sns.suspend_select = 1'b0;
        sns.skip_select = 1'b0;
        toggle_run();
        chk("uv cleared", 1'b0, fault);
    endtask
    task automatic t_thermal();
        int n;
        power_up(code, 0);
        sns.hot = 1'b1;
        sns.cooled = 1'b0;
        step(4);
        chk("hot latch", 1'b1, fault);
        wait_off(n);
        sns.hot = 1'b0;
        toggle_run();
        chk("warm hold", 1'b1, fault);
        sns.cooled = 1'b1;
        sns.supply_ok = 1'b0;
        sns.supply_low = 1'b1;
        step(6);
        chk("cool clear", 1'b0, fault);
        sns.supply_low = 1'b0;
    endtask
    task automatic t_test_mode();
        int n;
        sns.battery_ok = 1'b0;
        sns.below_target = 1'b1;
        sns.supply_ok = 1'b1;
        step(40);
        chk("no battery", 1'b1, fault);
        wait_off(n);
        sns.battery_ok = 1'b1;
        sns.test_mode = 1'b1;
        step(6);
        chk("test clear", 1'b0, fault);
        power_up(code, 0);
        sns.under_guard = 1'b1;
        sns.hot = 1'b1;
        sns.over_guard = 1'b1;
        step(6);
        chk("test latch", 1'b0, fault);
        chk("test ov", 1'b0, overvoltage_guard);
        chk("test runs", 1'b1, ref_on);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        sns = '0;
        sns.supply_por = 1'b1;
        sns.ref_ok = 1'b1;
        sns.battery_ok = 1'b1;
        sns.cooled = 1'b1;
        step(20);
        rst_b_i = 1'b1;
        step(4);
        chk("lockout skip", 1'b1, skip);
        chk("por fault", 1'b0, fault);
        t_start();
        t_overvolt();
        t_shutdown();
        t_undervolt();
        t_thermal();
        t_test_mode();
        sns.supply_ok = 1'b0;
        step(4);
        chk("drop skip", 1'b1, skip);
        chk("drop pulses", 8'h00, pulse);
        close_out();
    end
    // Hang guard well past the expected run of under two thousand cycles
    initial begin
        repeat (8000) @(posedge clk_sys_i);
        err_count++;
        $display("Error run length expected under %0d seen %0d", 8000, 8000);
        close_out();
    end
endmodule
